// ===== design/dftm_trip_monitor.sv
// Top of the drive fault-trip monitor: gathers conditions, blanks output.
// Assumes all inputs are synchronous to clk and nrst is the power-on reset.
//
// Overview of operation
// - Keypad clock back at defaults trips E042
// - Keypad clock check runs once per power-up
// - Option slot fault trips E060 to E069
// - Selection 02: both safety inputs off trips E090
// - Selection 00/01: warning with/without display only
// - Internal safety path failure trips E091
// - After E091 hold torque off until power off
// - Change action 02: either input off trips E092/E093
// - Change action 00/01: no path trip
// - Encoder wiring lost trips E100
// - Position beyond forward or reverse limit trips E104
`timescale 1ns/1ps
module dftm_trip_monitor import dftm_pkg::*; #(
	parameter int POS_W = DFTM_POS_W_DEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic trip_clear,
	input wire logic keypad_status_valid,
	input wire logic keypad_clock_at_default,
	input wire logic option_fault,
	input wire logic [DFTM_OPT_W-1:0] option_fault_index,
	input wire logic safety_input_a,
	input wire logic safety_input_b,
	input wire logic [1:0] sto_trip_select,
	input wire logic [1:0] safety_change_action,
	input wire logic safety_path_fault,
	input wire logic encoder_wire_lost,
	input wire logic signed [POS_W-1:0] position_now,
	input wire logic signed [POS_W-1:0] position_limit_forward,
	input wire logic signed [POS_W-1:0] position_limit_reverse,
	output logic power_stage_enable,
	output logic safe_torque_off,
	output logic trip_active,
	output logic trip_locked,
	output logic [DFTM_CODE_W-1:0] trip_code,
	output logic sto_warning,
	output logic sto_warning_display,
	output logic keypad_check_done
);
	generate
		if (POS_W < 2 || POS_W > 64) begin : g_bad_width
			$error("POS_W must lie between 2 and 64");
		end
	endgenerate

	dftm_trip_if trip_bus ();

	logic both_off;
	logic both_off_trip;
	logic path_a_trip;
	logic path_b_trip;
	logic keypad_fail_now;
	logic position_over;
	logic [DFTM_CODE_W-1:0] option_code;
	logic trip_any;
	logic [DFTM_CODE_W-1:0] req_code;

	logic kp_pend_ff, nxt_kp_pend;
	logic kp_err_ff, nxt_kp_err;
	logic pse_ff, nxt_pse;
	logic sto_ff, nxt_sto;

	dftm_sto_monitor u_sto (
		.clk(clk),
		.nrst(nrst),
		.safety_input_a(safety_input_a),
		.safety_input_b(safety_input_b),
		.sto_trip_select(sto_trip_select),
		.safety_change_action(safety_change_action),
		.both_off(both_off),
		.both_off_trip(both_off_trip),
		.path_a_trip(path_a_trip),
		.path_b_trip(path_b_trip),
		.sto_warning(sto_warning),
		.sto_warning_display(sto_warning_display)
	);

	dftm_trip_latch u_latch (
		.clk(clk),
		.nrst(nrst),
		.trip_clear(trip_clear),
		.trip(trip_bus.dst),
		.tripped(trip_active),
		.locked(trip_locked),
		.trip_code(trip_code)
	);

	// Keypad clock check, armed by power-on reset only
	assign keypad_fail_now = kp_pend_ff && keypad_status_valid && keypad_clock_at_default;

	always_comb begin
		nxt_kp_pend = kp_pend_ff;
		if (kp_pend_ff && keypad_status_valid) begin
			nxt_kp_pend = 1'b0;
		end
		nxt_kp_err = kp_err_ff;
		if (keypad_fail_now) begin
			nxt_kp_err = 1'b1;
		end else if (trip_clear) begin
			nxt_kp_err = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			kp_pend_ff <= DFTM_KP_PEND_RST;
			kp_err_ff <= 1'b0;
		end else begin
			kp_pend_ff <= nxt_kp_pend;
			kp_err_ff <= nxt_kp_err;
		end
	end

	assign keypad_check_done = !kp_pend_ff;

	// Option index above nine is reported as the last option code
	always_comb begin
		if (option_fault_index > DFTM_OPT_MAX) begin
			option_code = DFTM_CODE_E069;
		end else begin
			option_code = DFTM_CODE_E060 + {{(DFTM_CODE_W-DFTM_OPT_W){1'b0}}, option_fault_index};
		end
	end

	assign position_over = (position_now > position_limit_forward)
		|| (position_now < position_limit_reverse);

	// Safety faults take precedence; a keypad fault is the mildest
	always_comb begin
		trip_any = 1'b1;
		req_code = DFTM_CODE_NONE;
		if (safety_path_fault) begin
			req_code = DFTM_CODE_E091;
		end else if (both_off_trip) begin
			req_code = DFTM_CODE_E090;
		end else if (path_a_trip) begin
			req_code = DFTM_CODE_E092;
		end else if (path_b_trip) begin
			req_code = DFTM_CODE_E093;
		end else if (encoder_wire_lost) begin
			req_code = DFTM_CODE_E100;
		end else if (position_over) begin
			req_code = DFTM_CODE_E104;
		end else if (option_fault) begin
			req_code = option_code;
		end else if (kp_err_ff) begin
			req_code = DFTM_CODE_E042;
		end else begin
			trip_any = 1'b0;
		end
	end

	assign trip_bus.req = trip_any;
	assign trip_bus.code = req_code;

	// Output blanking and torque-off indication
	always_comb begin
		nxt_pse = !(trip_any || trip_active || both_off);
		nxt_sto = both_off || trip_locked || (trip_any && req_code == DFTM_CODE_E091);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pse_ff <= DFTM_PSE_RST;
			sto_ff <= 1'b0;
		end else begin
			pse_ff <= nxt_pse;
			sto_ff <= nxt_sto;
		end
	end

	assign power_stage_enable = pse_ff;
	assign safe_torque_off = sto_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	logic sto_req;
	assign sto_req = safety_path_fault || both_off_trip || path_a_trip || path_b_trip;

	sequence s_idle;
		!trip_active;
	endsequence

	sequence s_kp_fail;
		kp_pend_ff && keypad_status_valid && keypad_clock_at_default;
	endsequence

	sequence s_only_kp;
		!sto_req && !encoder_wire_lost && !position_over && !option_fault;
	endsequence

	a_trip_blanks: assert property (trip_any |=> !power_stage_enable && trip_active)
		else $error("output not blanked on trip");
	a_held_tripped: assert property (trip_active && !trip_clear |=> !power_stage_enable && trip_active)
		else $error("trip released without clear");
	a_keypad_code: assert property ((s_idle and s_kp_fail and s_only_kp) ##1 s_only_kp
		|=> trip_code == DFTM_CODE_E042)
		else $error("keypad clock fault not E042");
	a_keypad_once: assert property (keypad_status_valid && kp_pend_ff |=> keypad_check_done [*3])
		else $error("keypad check rearmed");
	a_option_code: assert property (s_idle
		and (option_fault && !sto_req && !encoder_wire_lost && !position_over)
		|=> trip_code >= DFTM_CODE_E060 && trip_code <= DFTM_CODE_E069)
		else $error("option fault code out of range");
	a_sto_trip: assert property (s_idle
		and (both_off && sto_trip_select == DFTM_STO_TRIP && !safety_path_fault)
		|=> trip_code == DFTM_CODE_E090)
		else $error("both inputs off did not trip E090");
	a_sto_warn_only: assert property (s_idle
		and (both_off && sto_trip_select == DFTM_STO_WARN_DISP && !safety_path_fault
		&& safety_change_action != DFTM_SCA_TRIP && !encoder_wire_lost
		&& !position_over && !option_fault && !kp_err_ff)
		|=> sto_warning && sto_warning_display && !trip_active)
		else $error("warning setting tripped");
	a_internal_lock: assert property (safety_path_fault |=> trip_locked && trip_code == DFTM_CODE_E091)
		else $error("internal failure not locked");
	a_lock_forever: assert property ($rose(trip_locked) |-> (trip_locked && safe_torque_off) [*8])
		else $error("torque off released after lock");
	a_path_a: assert property (s_idle
		and (!safety_input_a && safety_input_b && !safety_path_fault && safety_change_action == DFTM_SCA_TRIP)
		|=> trip_code == DFTM_CODE_E092)
		else $error("path A loss not E092");
	a_path_b: assert property (s_idle
		and (safety_input_a && !safety_input_b && !safety_path_fault && safety_change_action == DFTM_SCA_TRIP)
		|=> trip_code == DFTM_CODE_E093)
		else $error("path B loss not E093");
	a_path_quiet: assert property (s_idle and (safety_change_action != DFTM_SCA_TRIP)
		|=> trip_code != DFTM_CODE_E092 && trip_code != DFTM_CODE_E093)
		else $error("path trip while check off");
	a_encoder: assert property (s_idle and (encoder_wire_lost && !sto_req)
		|=> trip_code == DFTM_CODE_E100)
		else $error("encoder loss not E100");
	a_position: assert property (s_idle
		and (position_now > position_limit_forward && !sto_req && !encoder_wire_lost)
		|=> trip_code == DFTM_CODE_E104)
		else $error("position overrun not E104");
	a_clear_runs: assert property (trip_active && !trip_locked && trip_clear && !trip_any
		|=> !trip_active ##1 (power_stage_enable || trip_active || $past(both_off)))
		else $error("clear did not restore run");

	// Option index mapping and reverse limit
	sequence s_opt_alone;
		option_fault && !sto_req && !encoder_wire_lost && !position_over;
	endsequence

	a_option_high: assert property (s_idle and s_opt_alone
		and (option_fault_index > DFTM_OPT_MAX) |=> trip_code == DFTM_CODE_E069)
		else $error("option index above nine not E069");
	a_option_index: assert property (s_idle and s_opt_alone
		and (option_fault_index <= DFTM_OPT_MAX)
		|=> trip_code == DFTM_CODE_E060 + {{(DFTM_CODE_W-DFTM_OPT_W){1'b0}}, $past(option_fault_index)})
		else $error("option code does not follow index");
	a_reverse_limit: assert property (s_idle
		and (position_now < position_limit_reverse && !sto_req && !encoder_wire_lost)
		|=> trip_code == DFTM_CODE_E104)
		else $error("reverse overrun not E104");

	// Safety inputs, warnings and torque-off indication
	a_both_path: assert property (s_idle
		and (both_off && sto_trip_select != DFTM_STO_TRIP && safety_change_action == DFTM_SCA_TRIP
		&& !safety_path_fault) |=> trip_code == DFTM_CODE_E092)
		else $error("both off with path trip not E092");
	a_no_path_keep: assert property (safety_change_action != DFTM_SCA_TRIP |-> !path_a_trip && !path_b_trip)
		else $error("path trip raised while check off");
	a_no_sto_trip_warn: assert property (sto_trip_select != DFTM_STO_TRIP |-> !both_off_trip)
		else $error("warning setting raised a trip");
	a_warn_display: assert property (both_off && sto_trip_select == DFTM_STO_WARN_DISP
		|=> sto_warning && sto_warning_display) else $error("displayed warning missing");
	a_warn_trip_sel: assert property (sto_trip_select == DFTM_STO_TRIP |=> !sto_warning)
		else $error("warning raised in trip setting");
	a_warn_off: assert property (!both_off |=> !sto_warning && !sto_warning_display)
		else $error("warning without both inputs off");
	a_warn_blanks: assert property (both_off |=> !power_stage_enable)
		else $error("output not blanked while both off");
	a_sto_both_off: assert property (both_off |=> safe_torque_off)
		else $error("torque off not shown while both off");
	a_sto_release: assert property (!both_off && !trip_locked && !safety_path_fault |=> !safe_torque_off)
		else $error("torque off shown without cause");

	// Lock and code holding
	a_lock_sto: assert property (trip_locked |-> safe_torque_off)
		else $error("lock without torque off");
	a_lock_code: assert property (trip_locked |-> trip_code == DFTM_CODE_E091)
		else $error("lock code not E091");
	a_lock_blanks: assert property (trip_locked |=> trip_locked && !power_stage_enable)
		else $error("output enabled while locked");
	a_internal_sto: assert property (safety_path_fault |=> safe_torque_off)
		else $error("internal failure without torque off");
	a_code_idle: assert property (!trip_active |-> trip_code == DFTM_CODE_NONE)
		else $error("code shown while running");
	a_code_holds: assert property (trip_active && !trip_clear && !safety_path_fault |=> $stable(trip_code))
		else $error("latched code changed");

	// Keypad flag and release
	sequence s_open_trip;
		trip_active && !trip_locked;
	endsequence

	a_keypad_sets: assert property (s_kp_fail |=> kp_err_ff && keypad_check_done)
		else $error("keypad fault not recorded");
	a_keypad_late: assert property (keypad_check_done && !kp_err_ff |=> !kp_err_ff)
		else $error("keypad fault after check taken");
	a_keypad_clear: assert property (kp_err_ff && trip_clear |=> !kp_err_ff)
		else $error("keypad fault not cleared");
	a_run_enables: assert property (s_idle and (!trip_any && !both_off) |=> power_stage_enable)
		else $error("output not enabled while running");
	a_clear_standing: assert property (s_open_trip and (trip_clear && trip_any && !safety_path_fault)
		|=> trip_active && !trip_locked && trip_code != DFTM_CODE_NONE)
		else $error("clear released a standing trip");
endmodule : dftm_trip_monitor

// ===== design/dftm_pkg.sv
// Constants, codes and state types shared by the drive fault-trip monitor.
// Assumes trip codes are carried as their decimal error number in binary.
package dftm_pkg;
	localparam int DFTM_CODE_W = 8;
	localparam int DFTM_POS_W_DEF = 32;
	localparam int DFTM_OPT_W = 4;

	// Trip codes, value equals the error number
	localparam logic [7:0] DFTM_CODE_NONE = 8'h00;
	localparam logic [7:0] DFTM_CODE_E042 = 8'h2A;
	localparam logic [7:0] DFTM_CODE_E060 = 8'h3C;
	localparam logic [7:0] DFTM_CODE_E069 = 8'h45;
	localparam logic [7:0] DFTM_CODE_E090 = 8'h5A;
	localparam logic [7:0] DFTM_CODE_E091 = 8'h5B;
	localparam logic [7:0] DFTM_CODE_E092 = 8'h5C;
	localparam logic [7:0] DFTM_CODE_E093 = 8'h5D;
	localparam logic [7:0] DFTM_CODE_E100 = 8'h64;
	localparam logic [7:0] DFTM_CODE_E104 = 8'h68;
	localparam logic [3:0] DFTM_OPT_MAX = 4'h9;

	// Safe-torque-off indication selection
	localparam logic [1:0] DFTM_STO_WARN_DISP = 2'h0;
	localparam logic [1:0] DFTM_STO_WARN_QUIET = 2'h1;
	localparam logic [1:0] DFTM_STO_TRIP = 2'h2;

	// Safety-input-change action selection
	localparam logic [1:0] DFTM_SCA_KEEP = 2'h0;
	localparam logic [1:0] DFTM_SCA_OFF = 2'h1;
	localparam logic [1:0] DFTM_SCA_TRIP = 2'h2;

	// Reset values
	localparam logic DFTM_PSE_RST = 1'b0;
	localparam logic DFTM_KP_PEND_RST = 1'b1;

	typedef enum logic [2:0] {
		DFTM_ST_RUN = 3'h1,
		DFTM_ST_TRIP = 3'h2,
		DFTM_ST_LOCK = 3'h4
	} dftm_state_t;
endpackage : dftm_pkg

// ===== design/dftm_trip_if.sv
// Interface carrying the prioritised trip request to the trip latch.
// Assumes the source holds req as a level while any condition stands.
`timescale 1ns/1ps
interface dftm_trip_if;
	import dftm_pkg::*;
	logic req;
	logic [DFTM_CODE_W-1:0] code;
	modport src (output req, output code);
	modport dst (input req, input code);
endinterface : dftm_trip_if

// ===== design/dftm_sto_monitor.sv
// Safety input evaluation: both-off and single-path loss, plus warnings.
// Assumes safety inputs are high when on and synchronous to clk.
`timescale 1ns/1ps
module dftm_sto_monitor import dftm_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic safety_input_a,
	input wire logic safety_input_b,
	input wire logic [1:0] sto_trip_select,
	input wire logic [1:0] safety_change_action,
	output logic both_off,
	output logic both_off_trip,
	output logic path_a_trip,
	output logic path_b_trip,
	output logic sto_warning,
	output logic sto_warning_display
);
	logic warn_ff, nxt_warn;
	logic warn_disp_ff, nxt_warn_disp;

	assign both_off = !safety_input_a && !safety_input_b;
	assign both_off_trip = both_off && (sto_trip_select == DFTM_STO_TRIP);
	// Keep and disable settings raise no path trip
	assign path_a_trip = !safety_input_a && (safety_change_action == DFTM_SCA_TRIP);
	assign path_b_trip = !safety_input_b && (safety_change_action == DFTM_SCA_TRIP);

	always_comb begin
		nxt_warn = both_off && (sto_trip_select != DFTM_STO_TRIP);
		nxt_warn_disp = both_off && (sto_trip_select == DFTM_STO_WARN_DISP);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			warn_ff <= 1'b0;
			warn_disp_ff <= 1'b0;
		end else begin
			warn_ff <= nxt_warn;
			warn_disp_ff <= nxt_warn_disp;
		end
	end

	assign sto_warning = warn_ff;
	assign sto_warning_display = warn_disp_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_warn_quiet: assert property (both_off && sto_trip_select == DFTM_STO_WARN_QUIET
		|=> sto_warning && !sto_warning_display) else $error("quiet warning wrong");
endmodule : dftm_sto_monitor

// ===== design/dftm_trip_latch.sv
// Trip latch: holds the first trip code until a clear, which reloads any standing code instead of clearing; locks on E091.
// Assumes trip_clear is a synchronous request; only nrst leaves the lock.
`timescale 1ns/1ps
module dftm_trip_latch import dftm_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic trip_clear,
	dftm_trip_if.dst trip,
	output logic tripped,
	output logic locked,
	output logic [DFTM_CODE_W-1:0] trip_code
);
	dftm_state_t state_ff, nxt_state;
	logic [DFTM_CODE_W-1:0] code_ff, nxt_code;
	logic is_internal;

	assign is_internal = trip.req && (trip.code == DFTM_CODE_E091);

	always_comb begin
		nxt_state = state_ff;
		nxt_code = code_ff;
		unique case (state_ff)
			DFTM_ST_RUN: begin
				if (trip.req) begin
					nxt_state = is_internal ? DFTM_ST_LOCK : DFTM_ST_TRIP;
					nxt_code = trip.code;
				end
			end
			DFTM_ST_TRIP: begin
				if (is_internal) begin
					nxt_state = DFTM_ST_LOCK;
					nxt_code = DFTM_CODE_E091;
				end else if (trip_clear && trip.req) begin
					// A standing condition wins over the clear
					nxt_code = trip.code;
				end else if (trip_clear) begin
					nxt_state = DFTM_ST_RUN;
					nxt_code = DFTM_CODE_NONE;
				end
			end
			DFTM_ST_LOCK: begin
				nxt_state = DFTM_ST_LOCK;
				nxt_code = DFTM_CODE_E091;
			end
			default: begin
				nxt_state = DFTM_ST_LOCK;
				nxt_code = DFTM_CODE_E091;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= DFTM_ST_RUN;
			code_ff <= DFTM_CODE_NONE;
		end else begin
			state_ff <= nxt_state;
			code_ff <= nxt_code;
		end
	end

	assign tripped = (state_ff != DFTM_ST_RUN);
	assign locked = (state_ff == DFTM_ST_LOCK);
	assign trip_code = code_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_lock_ignores_clear: assert property (locked && trip_clear |=> locked && trip_code == DFTM_CODE_E091)
		else $error("lock left by clear");
endmodule : dftm_trip_latch

// ===== tb/dftm_keypad_model.sv
// Far-side keypad model: returns one clock status word per request.
// Assumes the bench raises kp_send for one clk cycle at a time.
`timescale 1ns/1ps
module dftm_keypad_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic kp_send,
	input wire logic kp_default,
	output logic keypad_status_valid,
	output logic keypad_clock_at_default
);
	logic churn_ff;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			keypad_status_valid <= 1'b0;
			keypad_clock_at_default <= 1'b0;
			churn_ff <= 1'b0;
		end else begin
			keypad_status_valid <= kp_send;
			churn_ff <= ~churn_ff;
			// Flag means nothing without valid, so it churns
			keypad_clock_at_default <= kp_send ? kp_default : churn_ff;
		end
	end
endmodule : dftm_keypad_model

// ===== tb/tb.sv
// Self-checking bench for the drive fault-trip monitor.
// Assumes the keypad model and the design files are compiled first.
`timescale 1ns/1ps
module tb;
	import dftm_pkg::*;
	localparam int PW = 8;
	typedef struct packed {
		logic a, b;
		logic [1:0] sel, sca;
		logic enc, opt;
		logic [3:0] idx;
		logic [7:0] pos, code;
		logic pse, warn, disp;
	} dftm_row_t;
	dftm_row_t rows [0:16] = '{
		'{1'h1, 1'h1, 2'h2, 2'h1, 1'h1, 1'h0, 4'h0, 8'h00, DFTM_CODE_E100, 1'h0, 1'h0, 1'h0},
		'{1'h1, 1'h1, 2'h2, 2'h1, 1'h0, 1'h1, 4'h0, 8'h00, DFTM_CODE_E060, 1'h0, 1'h0, 1'h0},
		'{1'h1, 1'h1, 2'h2, 2'h1, 1'h0, 1'h1, 4'h9, 8'h00, DFTM_CODE_E069, 1'h0, 1'h0, 1'h0},
		'{1'h1, 1'h1, 2'h2, 2'h1, 1'h0, 1'h1, 4'hC, 8'h00, DFTM_CODE_E069, 1'h0, 1'h0, 1'h0},
		'{1'h1, 1'h1, 2'h2, 2'h1, 1'h0, 1'h0, 4'h0, 8'h65, DFTM_CODE_E104, 1'h0, 1'h0, 1'h0},
		'{1'h1, 1'h1, 2'h2, 2'h1, 1'h0, 1'h0, 4'h0, 8'h9B, DFTM_CODE_E104, 1'h0, 1'h0, 1'h0},
		'{1'h1, 1'h1, 2'h2, 2'h1, 1'h0, 1'h0, 4'h0, 8'h64, DFTM_CODE_NONE, 1'h1, 1'h0, 1'h0},
		'{1'h0, 1'h0, 2'h2, 2'h1, 1'h0, 1'h0, 4'h0, 8'h00, DFTM_CODE_E090, 1'h0, 1'h0, 1'h0},
		'{1'h0, 1'h1, 2'h2, 2'h2, 1'h0, 1'h0, 4'h0, 8'h00, DFTM_CODE_E092, 1'h0, 1'h0, 1'h0},
		'{1'h1, 1'h0, 2'h2, 2'h2, 1'h0, 1'h0, 4'h0, 8'h00, DFTM_CODE_E093, 1'h0, 1'h0, 1'h0},
		'{1'h0, 1'h0, 2'h0, 2'h2, 1'h0, 1'h0, 4'h0, 8'h00, DFTM_CODE_E092, 1'h0, 1'h1, 1'h1},
		'{1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0, 4'h0, 8'h00, DFTM_CODE_NONE, 1'h0, 1'h1, 1'h1},
		'{1'h0, 1'h0, 2'h1, 2'h1, 1'h0, 1'h0, 4'h0, 8'h00, DFTM_CODE_NONE, 1'h0, 1'h1, 1'h0},
		'{1'h0, 1'h1, 2'h2, 2'h0, 1'h0, 1'h0, 4'h0, 8'h00, DFTM_CODE_NONE, 1'h1, 1'h0, 1'h0},
		'{1'h0, 1'h0, 2'h3, 2'h1, 1'h0, 1'h0, 4'h0, 8'h00, DFTM_CODE_NONE, 1'h0, 1'h1, 1'h0},
		'{1'h0, 1'h1, 2'h2, 2'h3, 1'h0, 1'h0, 4'h0, 8'h00, DFTM_CODE_NONE, 1'h1, 1'h0, 1'h0},
		'{1'h1, 1'h1, 2'h2, 2'h1, 1'h1, 1'h1, 4'h3, 8'h00, DFTM_CODE_E100, 1'h0, 1'h0, 1'h0}
	};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic trip_clear = 1'b0;
	logic kp_send = 1'b0;
	logic kp_default = 1'b0;
	logic sa = 1'b1;
	logic sb = 1'b1;
	logic [1:0] sel = 2'h2;
	logic [1:0] sca = 2'h1;
	logic spf = 1'b0;
	logic enc = 1'b0;
	logic opt = 1'b0;
	logic [3:0] idx = 4'h0;
	logic signed [PW-1:0] pos = 8'h00;
	logic signed [PW-1:0] lim_fwd = 8'h64;
	logic signed [PW-1:0] lim_rev = 8'h9C;
	logic kp_valid, kp_at_default;
	logic power_stage_enable, safe_torque_off, trip_active, trip_locked;
	logic [DFTM_CODE_W-1:0] trip_code;
	logic sto_warning, sto_warning_display, keypad_check_done;
	int num_errors = 0;
	int checked = 0;
	always #10 clk = ~clk;
	dftm_keypad_model kp (.clk(clk), .nrst(nrst), .kp_send(kp_send), .kp_default(kp_default),
		.keypad_status_valid(kp_valid), .keypad_clock_at_default(kp_at_default));
	dftm_trip_monitor #(.POS_W(PW)) dut (.clk(clk), .nrst(nrst), .trip_clear(trip_clear),
		.keypad_status_valid(kp_valid), .keypad_clock_at_default(kp_at_default), .option_fault(opt),
		.option_fault_index(idx), .safety_input_a(sa), .safety_input_b(sb), .sto_trip_select(sel),
		.safety_change_action(sca), .safety_path_fault(spf), .encoder_wire_lost(enc),
		.position_now(pos), .position_limit_forward(lim_fwd), .position_limit_reverse(lim_rev),
		.power_stage_enable(power_stage_enable), .safe_torque_off(safe_torque_off),
		.trip_active(trip_active), .trip_locked(trip_locked), .trip_code(trip_code),
		.sto_warning(sto_warning), .sto_warning_display(sto_warning_display),
		.keypad_check_done(keypad_check_done));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : cycles
	task automatic do_reset;
		nrst = 1'b0;
		cycles(16);
		chk(trip_code, DFTM_CODE_NONE);
		chk(power_stage_enable, 1'b0);
		nrst = 1'b1;
		cycles(2);
	endtask : do_reset
	task automatic clear_all;
		{sa, sb, sel, sca, enc, opt, idx, pos, spf} = {1'b1, 1'b1, 2'h2, 2'h1, 1'b0, 1'b0, 4'h0, 8'h00, 1'b0};
		// Two cycles: the first may only consume the keypad flag
		trip_clear = 1'b1;
		cycles(2);
		trip_clear = 1'b0;
		cycles(2);
		chk(trip_active, 1'b0);
		chk(power_stage_enable, 1'b1);
	endtask : clear_all
	task automatic kp_word(input logic dflt);
		kp_default = dflt;
		kp_send = 1'b1;
		cycles(1);
		kp_send = 1'b0;
		cycles(3);
	endtask : kp_word
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		#40000;
		num_errors++;
		complete_run();
	end
	initial begin
		do_reset();
		for (int i = 0; i < 17; i++) begin
			{sa, sb, sel, sca, enc, opt, idx, pos} = rows[i][30:11];
			cycles(2);
			chk(trip_code, rows[i].code);
			chk(power_stage_enable, rows[i].pse);
			chk(sto_warning, rows[i].warn);
			chk(sto_warning_display, rows[i].disp);
			clear_all();
			$display("row %0d done", i);
		end
		// Keypad word at defaults trips once per power-up
		kp_word(1'b1);
		chk(keypad_check_done, 1'b1);
		chk(trip_code, DFTM_CODE_E042);
		chk(power_stage_enable, 1'b0);
		// One clear pulse only drops the sticky keypad flag
		trip_clear = 1'b1;
		cycles(1);
		trip_clear = 1'b0;
		cycles(1);
		chk(trip_active, 1'b1);
		chk(trip_code, DFTM_CODE_E042);
		clear_all();
		kp_word(1'b1);
		chk(trip_active, 1'b0);
		do_reset();
		kp_word(1'b1);
		chk(trip_code, DFTM_CODE_E042);
		clear_all();
		$display("keypad test done");
		// Clear while the condition stands, later condition ignored
		enc = 1'b1;
		cycles(2);
		opt = 1'b1;
		trip_clear = 1'b1;
		cycles(1);
		trip_clear = 1'b0;
		cycles(2);
		chk(trip_code, DFTM_CODE_E100);
		chk(power_stage_enable, 1'b0);
		clear_all();
		$display("held trip test done");
		// Internal path failure locks until power-up
		spf = 1'b1;
		cycles(1);
		spf = 1'b0;
		cycles(1);
		chk(trip_locked, 1'b1);
		chk(trip_code, DFTM_CODE_E091);
		chk(safe_torque_off, 1'b1);
		trip_clear = 1'b1;
		cycles(1);
		trip_clear = 1'b0;
		cycles(4);
		chk(trip_locked, 1'b1);
		chk(safe_torque_off, 1'b1);
		chk(power_stage_enable, 1'b0);
		do_reset();
		chk(trip_locked, 1'b0);
		chk(power_stage_enable, 1'b1);
		$display("lock test done");
		complete_run();
	end
endmodule : tb
